// File: rtl/psq_pkg.sv
// Constants shared by the preset reference and stage sequencer design.
package psq_pkg;
  // Register word addresses.
  localparam logic [7:0] ADDR_PRESET_BASE = 8'h00; // 16 presets
  localparam logic [7:0] ADDR_TIME_BASE   = 8'h10; // 16 stage durations
  localparam logic [7:0] ADDR_ACCEL_BASE  = 8'h20; // 16 ramp selectors
  localparam logic [7:0] ADDR_CTRL        = 8'h30;
  localparam logic [7:0] ADDR_MAX_FREQ    = 8'h31;
  localparam logic [7:0] ADDR_RATED_VOLT  = 8'h32;
  localparam logic [7:0] ADDR_STATUS      = 8'h33;

  // Control register field positions.
  localparam int CTRL_MODE_LSB = 0;  // Two bits, sequencer_run_mode.
  localparam int CTRL_RET_PWR  = 2;  // Power-down retention digit.
  localparam int CTRL_RET_STOP = 3;  // Stop retention digit.
  localparam int CTRL_UNIT     = 4;  // stage_time_unit.
  localparam int CTRL_SRC_LSB  = 5;  // Three bits, preset_zero_source.

  // Reset values.
  localparam logic [15:0] PRESET_RST     = 16'h0000;
  localparam logic [15:0] TIME_RST       = 16'h0000;
  localparam logic [1:0]  ACCEL_RST      = 2'h0;
  localparam logic [15:0] MAX_FREQ_RST   = 16'h1388;
  localparam logic [15:0] RATED_VOLT_RST = 16'h017c;

  // Limits: presets in tenths of a percent, durations in tenths of a unit.
  localparam logic signed [15:0] PRESET_MAX = 16'sh03e8;
  localparam logic signed [15:0] PRESET_MIN = -16'sh03e8;
  localparam logic [15:0]        TIME_MAX   = 16'hfde8;
  localparam logic signed [32:0] PCT_FULL   = 33'sh3e8;

  // Sequencer run modes.
  localparam logic [1:0] MODE_ONCE  = 2'h0;
  localparam logic [1:0] MODE_HOLD  = 2'h1;
  localparam logic [1:0] MODE_CYCLE = 2'h2;

  // Preset zero source codes.
  localparam logic [2:0] SRC_STORED = 3'h0;
  localparam logic [2:0] SRC_AIN1   = 3'h1;
  localparam logic [2:0] SRC_AIN2   = 3'h2;
  localparam logic [2:0] SRC_AIN3   = 3'h3;
  localparam logic [2:0] SRC_PULSE  = 3'h4;
  localparam logic [2:0] SRC_PID    = 3'h5;
  localparam logic [2:0] SRC_UPDOWN = 3'h6;

  // Duration step timing.
  localparam int CLK_HZ          = 20000000;
  localparam int TENTH_SEC_MS    = 100;
  localparam int TENTH_CYCLES    = CLK_HZ / 1000 * TENTH_SEC_MS;
  localparam int SEC_PER_HOUR    = 3600;
  localparam logic [11:0] HOUR_TENTHS = 12'(SEC_PER_HOUR - 1);

  // Sequencer states.
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_HOLD} psq_state_t;
endpackage

// File: rtl/psq_tick_gen.sv
// Divider making the one-cycle duration step pulse for the sequencer.
`timescale 1ns/10ps
`default_nettype none
module psq_tick_gen #(
  parameter int TENTH_CYCLES = psq_pkg::TENTH_CYCLES
) (
  input  wire logic core_clk,   // Control clock.
  input  wire logic reset,      // Asynchronous reset, active high.
  input  wire logic enable,     // Counts only while a stage runs.
  input  wire logic unit_hours, // Step is a tenth of an hour when high.
  output logic      step        // One-cycle duration step pulse.
);
  logic [23:0] div_q;
  logic [11:0] hour_q;
  logic        tenth_w;
  logic        hour_end_w;

  // A tenth of a second has passed when the divider wraps.
  assign tenth_w    = enable && (div_q == 24'(TENTH_CYCLES - 1));
  assign hour_end_w = hour_q == psq_pkg::HOUR_TENTHS;
  assign step       = tenth_w && (!unit_hours || hour_end_w);

  // The divider restarts whenever counting is paused.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      div_q  <= 24'h000000;
      hour_q <= 12'h000;
    end else if (!enable) begin
      div_q  <= 24'h000000;
      hour_q <= 12'h000;
    end else if (tenth_w) begin
      div_q  <= 24'h000000;
      hour_q <= hour_end_w ? 12'h000 : hour_q + 12'h001;
    end else begin
      div_q  <= div_q + 24'h000001;
    end
  end
endmodule // psq_tick_gen
`default_nettype wire

// File: rtl/psq_scale.sv
// Registered scaling of a relative reference to an absolute command.
`timescale 1ns/10ps
`default_nettype none
module psq_scale (
  input  wire logic               core_clk, // Control clock.
  input  wire logic               reset,    // Asynchronous reset.
  input  wire logic signed [15:0] ref_pct,  // Reference, tenths of percent.
  input  wire logic        [15:0] full,     // Value at one hundred percent.
  output logic signed      [16:0] scaled    // ref_pct times full over 1000.
);
  logic signed [32:0] prod_w;
  logic signed [32:0] quot_w;

  // Full-width product and quotient, then trimmed.
  assign prod_w = 33'(ref_pct) * $signed({17'h00000, full});
  assign quot_w = prod_w / psq_pkg::PCT_FULL;

  // The result is held in a flip-flop so the output is glitch free.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      scaled <= 17'sh00000;
    end else begin
      scaled <= quot_w[16:0];
    end
  end
endmodule // psq_scale
`default_nettype wire

// File: rtl/psq_top.sv
// Preset reference selector and stage sequencer of the drive.
`timescale 1ns/10ps
`default_nettype none
module psq_top #(
  parameter int TENTH_CYCLES = psq_pkg::TENTH_CYCLES
) (
  input  wire logic        core_clk,             // 20 MHz control clock.
  input  wire logic        reset,                // Async reset, high.
  input  wire logic [7:0]  reg_addr,             // Register word address.
  input  wire logic [15:0] reg_wdata,            // Register write data.
  input  wire logic        reg_we,               // Write strobe.
  input  wire logic        reg_re,               // Read strobe.
  output logic      [15:0] reg_rdata,            // Read data, next cycle.
  input  wire logic [3:0]  preset_sel_pins,      // Selection terminals.
  input  wire logic        power_fail,           // Power loss pin.
  input  wire logic        run_cmd,              // Run level, low stops.
  input  wire logic [15:0] analog_input_one,     // Analog input one.
  input  wire logic [15:0] analog_input_two,     // Analog input two.
  input  wire logic [15:0] analog_input_three,   // Analog input three.
  input  wire logic [15:0] pulse_input_terminal, // Pulse input setting.
  input  wire logic [15:0] pid_output,           // PID output.
  input  wire logic [15:0] updown_setting,       // Up/down digital value.
  input  wire logic        nv_valid_in,          // Saved image is valid.
  input  wire logic [3:0]  nv_stage_in,          // Saved stage.
  input  wire logic [16:0] nv_freq_in,           // Saved frequency.
  output logic             nv_save,              // Save pulse.
  output logic      [3:0]  nv_stage,             // Stage to save.
  output logic      [16:0] nv_freq,              // Frequency to save.
  output logic      [16:0] resume_freq,          // Retained frequency.
  output logic signed [16:0] freq_cmd,           // Frequency command.
  output logic signed [16:0] volt_cmd,           // V/F voltage command.
  output logic      [15:0] pid_setpoint,         // PID setpoint.
  output logic      [1:0]  accel_sel,            // Ramp set selector.
  output logic      [3:0]  seq_stage,            // Stage in force.
  output logic             seq_running           // Sequencer is running.
);
  logic [15:0] preset_q [16];
  logic [15:0] time_q   [16];
  logic [1:0]  accel_q  [16];
  logic [7:0]  ctrl_q;
  logic [15:0] max_freq_q;
  logic [15:0] rated_volt_q;
  logic [3:0]  pin_meta_q;
  logic [3:0]  pin_sync_q;
  logic        pf_meta_q;
  logic        pf_sync_q;
  logic        pf_last_q;
  logic        run_last_q;
  logic        boot_q;
  logic        restore_pend_q;
  logic        restore_ok_q;
  logic [3:0]  restore_stage_q;
  psq_pkg::psq_state_t state_q;
  logic [3:0]  stage_q;
  logic [3:0]  ref_stage_q;
  logic [15:0] elapsed_q;

  // Register decode and field views.
  logic        sel_preset_w;
  logic        sel_time_w;
  logic        sel_accel_w;
  logic [3:0]  idx_w;
  logic [1:0]  mode_w;
  logic        ret_pwr_w;
  logic        ret_stop_w;
  logic [2:0]  src_w;
  logic signed [15:0] wr_signed_w;
  logic [15:0] wr_preset_w;
  logic [15:0] wr_time_w;
  logic [7:0]  wr_ctrl_w;
  logic [15:0] status_w;
  logic [15:0] rd_word_w;

  assign sel_preset_w = reg_addr[7:4] == psq_pkg::ADDR_PRESET_BASE[7:4];
  assign sel_time_w   = reg_addr[7:4] == psq_pkg::ADDR_TIME_BASE[7:4];
  assign sel_accel_w  = reg_addr[7:4] == psq_pkg::ADDR_ACCEL_BASE[7:4];
  assign idx_w        = reg_addr[3:0];
  assign mode_w       = ctrl_q[psq_pkg::CTRL_MODE_LSB +: 2];
  assign ret_pwr_w    = ctrl_q[psq_pkg::CTRL_RET_PWR];
  assign ret_stop_w   = ctrl_q[psq_pkg::CTRL_RET_STOP];
  assign src_w        = ctrl_q[psq_pkg::CTRL_SRC_LSB +: 3];
  assign wr_signed_w  = $signed(reg_wdata);

  // Preset, duration and mode writes are clamped to their legal ranges; an illegal source code selects the stored preset.
  assign wr_preset_w =
    (wr_signed_w > psq_pkg::PRESET_MAX) ? psq_pkg::PRESET_MAX :
    (wr_signed_w < psq_pkg::PRESET_MIN) ? psq_pkg::PRESET_MIN :
    reg_wdata;
  assign wr_time_w = (reg_wdata > psq_pkg::TIME_MAX) ?
                     psq_pkg::TIME_MAX : reg_wdata;
  assign wr_ctrl_w = {
    (reg_wdata[7:5] > psq_pkg::SRC_UPDOWN) ? psq_pkg::SRC_STORED :
                                             reg_wdata[7:5],
    reg_wdata[4:2],
    (reg_wdata[1:0] > psq_pkg::MODE_CYCLE) ? psq_pkg::MODE_CYCLE :
                                             reg_wdata[1:0]};

  // Status word shows the sequencer and the selected terminal index.
  assign status_w = {2'h0, pin_sync_q, state_q == psq_pkg::SEQ_HOLD,
                     seq_running, 4'h0, stage_q};

  // Read selection; unmapped addresses read as zero.
  assign rd_word_w =
    sel_preset_w ? preset_q[idx_w] :
    sel_time_w   ? time_q[idx_w] :
    sel_accel_w  ? {14'h0000, accel_q[idx_w]} :
    (reg_addr == psq_pkg::ADDR_CTRL)       ? {8'h00, ctrl_q} :
    (reg_addr == psq_pkg::ADDR_MAX_FREQ)   ? max_freq_q :
    (reg_addr == psq_pkg::ADDR_RATED_VOLT) ? rated_volt_q :
    (reg_addr == psq_pkg::ADDR_STATUS)     ? status_w : 16'h0000;

  // Register file writes and the registered read answer.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 16; i++) begin
        preset_q[i] <= psq_pkg::PRESET_RST;
        time_q[i]   <= psq_pkg::TIME_RST;
        accel_q[i]  <= psq_pkg::ACCEL_RST;
      end
      ctrl_q       <= 8'h00;
      max_freq_q   <= psq_pkg::MAX_FREQ_RST;
      rated_volt_q <= psq_pkg::RATED_VOLT_RST;
      reg_rdata    <= 16'h0000;
    end else begin
      if (reg_we && sel_preset_w) preset_q[idx_w] <= wr_preset_w;
      if (reg_we && sel_time_w)   time_q[idx_w]   <= wr_time_w;
      if (reg_we && sel_accel_w)  accel_q[idx_w]  <= reg_wdata[1:0];
      if (reg_we && reg_addr == psq_pkg::ADDR_CTRL) ctrl_q <= wr_ctrl_w;
      if (reg_we && reg_addr == psq_pkg::ADDR_MAX_FREQ)
        max_freq_q <= reg_wdata;
      if (reg_we && reg_addr == psq_pkg::ADDR_RATED_VOLT)
        rated_volt_q <= reg_wdata;
      reg_rdata <= reg_re ? rd_word_w : 16'h0000;
    end
  end

  // Selection and power loss pins pass two flip-flops before use; run_cmd is used directly.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pin_meta_q <= 4'h0;
      pin_sync_q <= 4'h0;
      pf_meta_q  <= 1'b0;
      pf_sync_q  <= 1'b0;
      pf_last_q  <= 1'b0;
      run_last_q <= 1'b0;
    end else begin
      pin_meta_q <= preset_sel_pins;
      pin_sync_q <= pin_meta_q;
      pf_meta_q  <= power_fail;
      pf_sync_q  <= pf_meta_q;
      pf_last_q  <= pf_sync_q;
      run_last_q <= run_cmd;
    end
  end

  // Sequencer timing and stage control.
  logic        step_w;
  logic        run_rise_w;
  logic        stage_zero_w;
  logic        stage_end_w;
  logic        last_stage_w;
  logic [3:0]  start_stage_w;

  assign run_rise_w   = run_cmd && !run_last_q;
  assign stage_zero_w = time_q[stage_q] == 16'h0000;
  assign stage_end_w  = stage_zero_w ||
                        (step_w && (elapsed_q + 16'h0001 >=
                                    time_q[stage_q]));
  assign last_stage_w = stage_q == 4'hf;
  assign start_stage_w =
    (restore_pend_q && ret_pwr_w && restore_ok_q) ? restore_stage_q :
    (restore_pend_q || !ret_stop_w) ? 4'h0 : stage_q;

  psq_tick_gen #(.TENTH_CYCLES(TENTH_CYCLES)) u_tick (
    .core_clk   (core_clk),
    .reset      (reset),
    .enable     (state_q == psq_pkg::SEQ_RUN && !stage_zero_w),
    .unit_hours (ctrl_q[psq_pkg::CTRL_UNIT]),
    .step       (step_w)
  );

  // Stage state machine; a stop always returns to idle.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q     <= psq_pkg::SEQ_IDLE;
      stage_q     <= 4'h0;
      ref_stage_q <= 4'h0;
      elapsed_q   <= 16'h0000;
    end else begin
      unique case (state_q)
        psq_pkg::SEQ_IDLE: begin
          if (run_rise_w) begin
            state_q   <= psq_pkg::SEQ_RUN;
            stage_q   <= start_stage_w;
            elapsed_q <= 16'h0000;
          end
        end
        psq_pkg::SEQ_RUN: begin
          if (!stage_zero_w) ref_stage_q <= stage_q;
          if (!run_cmd) begin
            state_q <= psq_pkg::SEQ_IDLE;
            if (!ret_stop_w) stage_q <= 4'h0;
          end else if (stage_end_w) begin
            elapsed_q <= 16'h0000;
            stage_q   <= stage_q + 4'h1;
            if (last_stage_w) begin
              unique case (mode_w)
                psq_pkg::MODE_HOLD: begin
                  state_q <= psq_pkg::SEQ_HOLD;
                  stage_q <= stage_q;
                end
                psq_pkg::MODE_CYCLE: state_q <= psq_pkg::SEQ_RUN;
                default: state_q <= psq_pkg::SEQ_IDLE;
              endcase
            end
          end else if (step_w) begin
            elapsed_q <= elapsed_q + 16'h0001;
          end
        end
        psq_pkg::SEQ_HOLD: begin
          if (!run_cmd) begin
            state_q <= psq_pkg::SEQ_IDLE;
            if (!ret_stop_w) stage_q <= 4'h0;
          end
        end
      endcase
    end
  end

  // Power-up restore image is caught in the first cycle after release.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      boot_q          <= 1'b1;
      restore_pend_q  <= 1'b1;
      restore_ok_q    <= 1'b0;
      restore_stage_q <= 4'h0;
    end else begin
      boot_q <= 1'b0;
      if (boot_q) begin
        restore_ok_q    <= nv_valid_in;
        restore_stage_q <= nv_stage_in;
      end
      if (state_q == psq_pkg::SEQ_IDLE && run_rise_w)
        restore_pend_q <= 1'b0;
    end
  end

  // Reference selection: sequencer stage while running, else terminals.
  logic [3:0]  ref_idx_w;
  logic [15:0] preset0_w;
  logic [15:0] ref_w;

  assign ref_idx_w = seq_running ? ref_stage_q : pin_sync_q;
  assign preset0_w =
    (src_w == psq_pkg::SRC_AIN1)   ? analog_input_one :
    (src_w == psq_pkg::SRC_AIN2)   ? analog_input_two :
    (src_w == psq_pkg::SRC_AIN3)   ? analog_input_three :
    (src_w == psq_pkg::SRC_PULSE)  ? pulse_input_terminal :
    (src_w == psq_pkg::SRC_PID)    ? pid_output :
    (src_w == psq_pkg::SRC_UPDOWN) ? updown_setting :
    preset_q[0];
  assign ref_w = (ref_idx_w == 4'h0) ? preset0_w : preset_q[ref_idx_w];

  psq_scale u_freq (
    .core_clk (core_clk),
    .reset    (reset),
    .ref_pct  ($signed(ref_w)),
    .full     (max_freq_q),
    .scaled   (freq_cmd)
  );

  psq_scale u_volt (
    .core_clk (core_clk),
    .reset    (reset),
    .ref_pct  ($signed(ref_w)),
    .full     (rated_volt_q),
    .scaled   (volt_cmd)
  );

  // Outputs that follow the sequencer, and the retention images.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pid_setpoint <= 16'h0000;
      accel_sel    <= 2'h0;
      seq_stage    <= 4'h0;
      seq_running  <= 1'b0;
      nv_save      <= 1'b0;
      nv_stage     <= 4'h0;
      nv_freq      <= 17'h00000;
      resume_freq  <= 17'h00000;
    end else begin
      pid_setpoint <= ref_w;
      accel_sel    <= accel_q[ref_stage_q];
      seq_stage    <= ref_stage_q;
      seq_running  <= state_q != psq_pkg::SEQ_IDLE;
      nv_save      <= pf_sync_q && !pf_last_q && ret_pwr_w;
      nv_stage     <= stage_q;
      nv_freq      <= freq_cmd;
      if (state_q != psq_pkg::SEQ_IDLE && !run_cmd && ret_stop_w)
        resume_freq <= freq_cmd;
      else if (boot_q)
        resume_freq <= nv_freq_in;
    end
  end
endmodule // psq_top
`default_nettype wire

// File: sim/psq_top_asserts.sv
// Port-level checker for the preset reference and stage sequencer.
`timescale 1ns/10ps
`default_nettype none
module psq_top_chk (
  input wire logic               core_clk,   // Control clock.
  input wire logic               reset,      // Async reset, high.
  input wire logic               reg_re,     // Read strobe.
  input wire logic        [15:0] reg_rdata,  // Read data.
  input wire logic               power_fail, // Power loss pin.
  input wire logic               run_cmd,    // Run level.
  input wire logic               nv_save,    // Save pulse.
  input wire logic signed [16:0] freq_cmd,   // Frequency command.
  input wire logic signed [16:0] volt_cmd,   // Voltage command.
  input wire logic        [3:0]  seq_stage,  // Stage in force.
  input wire logic               seq_running // Sequencer running.
);
  // One clock; checks rest in reset.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // Read data is zero unless a read came before.
  property p_rd_idle;
    !$past(reg_re) |-> reg_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data shown without a read");
  // Save pulse: one cycle, after a power loss edge.
  property p_save_pulse;
    nv_save |=> !nv_save;
  endproperty
  a_save_pulse: assert property (p_save_pulse)
    else $error("save pulse longer than one cycle");
  property p_save_cause;
    nv_save |-> $past(power_fail, 3) && !$past(power_fail, 4);
  endproperty
  a_save_cause: assert property (p_save_cause)
    else $error("save pulse without a power loss edge");
  // Both commands scale one signed reference.
  property p_sign_pos;
    freq_cmd > 17'sh00000 |-> volt_cmd >= 17'sh00000;
  endproperty
  a_sign_pos: assert property (p_sign_pos)
    else $error("voltage sign differs from frequency sign");
  property p_sign_neg;
    freq_cmd < 17'sh00000 |-> volt_cmd <= 17'sh00000;
  endproperty
  a_sign_neg: assert property (p_sign_neg)
    else $error("voltage sign differs from frequency sign");
  // Running starts only from a run command and ends after a stop.
  property p_run_rise;
    $rose(seq_running) |-> $past(run_cmd, 2);
  endproperty
  a_run_rise: assert property (p_run_rise)
    else $error("sequencer started without a run command");
  property p_stop;
    !run_cmd [*3] |=> !seq_running;
  endproperty
  a_stop: assert property (p_stop)
    else $error("sequencer still running after stop");
  // The stage moves only around a run or a stop.
  property p_stage_quiet;
    $changed(seq_stage) |-> run_cmd || seq_running || $past(seq_running);
  endproperty
  a_stage_quiet: assert property (p_stage_quiet)
    else $error("stage changed while idle");
endmodule // psq_top_chk

bind psq_top psq_top_chk u_psq_top_chk (
  .core_clk(core_clk), .reset(reset), .reg_re(reg_re),
  .reg_rdata(reg_rdata), .power_fail(power_fail), .run_cmd(run_cmd),
  .nv_save(nv_save), .freq_cmd(freq_cmd), .volt_cmd(volt_cmd),
  .seq_stage(seq_stage), .seq_running(seq_running)
);
`default_nettype wire

// File: sim/psq_far_model.sv
// Far-side model: reference sources and the retained image memory.
`timescale 1ns/10ps
`default_nettype none
module psq_far_model (
  input  wire logic        core_clk,             // Control clock.
  input  wire logic        nv_save,              // Save pulse.
  input  wire logic [3:0]  nv_stage,             // Stage to keep.
  input  wire logic [16:0] nv_freq,              // Frequency to keep.
  output logic      [15:0] analog_input_one,     // Source value.
  output logic      [15:0] analog_input_two,     // Source value.
  output logic      [15:0] analog_input_three,   // Source value.
  output logic      [15:0] pulse_input_terminal, // Source value.
  output logic      [15:0] pid_output,           // Source value.
  output logic      [15:0] updown_setting,       // Source value.
  output logic             nv_valid_in,          // Image is valid.
  output logic      [3:0]  nv_stage_in,          // Kept stage.
  output logic      [16:0] nv_freq_in            // Kept frequency.
);
  // One distinct value per source.
  assign analog_input_one     = 16'h0111;
  assign analog_input_two     = 16'h0122;
  assign analog_input_three   = 16'h0133;
  assign pulse_input_terminal = 16'h0144;
  assign pid_output           = 16'h0155;
  assign updown_setting       = 16'h0166;

  // The memory is empty at power-up and survives the block's reset.
  initial begin
    nv_valid_in = 1'b0;
    nv_stage_in = 4'h0;
    nv_freq_in  = 17'h00000;
  end

  // Keeps the image of each save pulse.
  always @(posedge core_clk) begin
    if (nv_save) begin
      nv_valid_in <= 1'b1;
      nv_stage_in <= nv_stage;
      nv_freq_in  <= nv_freq;
    end
  end
endmodule // psq_far_model
`default_nettype wire

// File: sim/test_psq_top.sv
// Self-checking bench for the preset reference and stage sequencer.
`timescale 1ns/10ps
`default_nettype none
module test_psq_top;
  localparam logic [7:0] A_PR = psq_pkg::ADDR_PRESET_BASE;
  localparam logic [7:0] A_TM = psq_pkg::ADDR_TIME_BASE;
  localparam logic [7:0] A_AC = psq_pkg::ADDR_ACCEL_BASE;
  localparam logic [7:0] A_CT = psq_pkg::ADDR_CTRL;
  localparam int         LIMIT = 20000;
  logic               core_clk = 1'b0;
  logic               reset = 1'b1;
  logic        [7:0]  reg_addr = 8'h00;
  logic        [15:0] reg_wdata = 16'h0000;
  logic               reg_we = 1'b0;
  logic               reg_re = 1'b0;
  logic        [3:0]  preset_sel_pins = 4'h0;
  logic               power_fail = 1'b0;
  logic               run_cmd = 1'b0;
  logic        [15:0] reg_rdata, pid_setpoint, analog_input_one;
  logic        [15:0] analog_input_two, analog_input_three;
  logic        [15:0] pulse_input_terminal, pid_output, updown_setting;
  logic               nv_valid_in, nv_save, seq_running;
  logic        [3:0]  nv_stage_in, nv_stage, seq_stage;
  logic        [16:0] nv_freq_in, nv_freq, resume_freq;
  logic signed [16:0] freq_cmd, volt_cmd;
  logic        [1:0]  accel_sel;
  int                 n_mismatch = 0;
  int                 compares = 0;
  int                 cycles = 0;
  logic        [15:0] src_exp [8] = '{16'h0064, 16'h0111, 16'h0122,
    16'h0133, 16'h0144, 16'h0155, 16'h0166, 16'h0064};

  psq_top #(.TENTH_CYCLES(4)) u_psq_top (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .preset_sel_pins(preset_sel_pins),
    .power_fail(power_fail), .run_cmd(run_cmd),
    .analog_input_one(analog_input_one),
    .analog_input_two(analog_input_two),
    .analog_input_three(analog_input_three),
    .pulse_input_terminal(pulse_input_terminal),
    .pid_output(pid_output), .updown_setting(updown_setting),
    .nv_valid_in(nv_valid_in), .nv_stage_in(nv_stage_in),
    .nv_freq_in(nv_freq_in), .nv_save(nv_save), .nv_stage(nv_stage),
    .nv_freq(nv_freq), .resume_freq(resume_freq), .freq_cmd(freq_cmd),
    .volt_cmd(volt_cmd), .pid_setpoint(pid_setpoint),
    .accel_sel(accel_sel), .seq_stage(seq_stage),
    .seq_running(seq_running));

  psq_far_model u_psq_far_model (
    .core_clk(core_clk), .nv_save(nv_save), .nv_stage(nv_stage),
    .nv_freq(nv_freq), .analog_input_one(analog_input_one),
    .analog_input_two(analog_input_two),
    .analog_input_three(analog_input_three),
    .pulse_input_terminal(pulse_input_terminal),
    .pid_output(pid_output), .updown_setting(updown_setting),
    .nv_valid_in(nv_valid_in), .nv_stage_in(nv_stage_in),
    .nv_freq_in(nv_freq_in));

  // A 50 ns clock and a hang guard.
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // Prints counts and verdict, ends the run.
  task automatic give_verdict();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Compares seen with expected.
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Register port cycles and settling waits.
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_we    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_re   <= 1'b0;
    #1;
    check(17'(reg_rdata), 17'(e));
  endtask

  // Selects a preset by pins, checks the commands.
  task automatic sel(input logic [3:0] i, input logic [15:0] p,
                     input logic [16:0] ef, input logic [16:0] ev);
    wr(A_PR + 8'(i), p);
    @(posedge core_clk) preset_sel_pins <= i;
    cyc(8);
    check(freq_cmd, ef);
    check(volt_cmd, ev);
    check(17'(pid_setpoint), 17'(p));
  endtask

  // Stage table, run level and waits.
  task automatic prog();
    wr(A_TM, 16'h0005);
    wr(A_TM + 8'h01, 16'h0000);
    wr(A_TM + 8'h02, 16'h0003);
    wr(A_AC, 16'h0001);
    wr(A_AC + 8'h02, 16'h0002);
  endtask
  task automatic run(input logic v);
    @(posedge core_clk) run_cmd <= v;
    cyc(3);
  endtask
  task automatic wait_stage(input logic [3:0] s);
    repeat (300) if (seq_stage !== s) cyc(1);
    check(17'(seq_stage), 17'(s));
  endtask
  task automatic wait_run(input logic v);
    repeat (300) if (seq_running !== v) cyc(1);
    check(17'(seq_running), 17'(v));
  endtask

  // The scenarios, in order.
  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    cyc(2);
    rd(A_PR + 8'h07, 16'h0000);
    rd(A_TM + 8'h03, 16'h0000);
    rd(psq_pkg::ADDR_MAX_FREQ, 16'h1388);
    rd(psq_pkg::ADDR_RATED_VOLT, 16'h017c);
    rd(8'h40, 16'h0000);
    wr(A_PR + 8'h01, 16'h0400);
    rd(A_PR + 8'h01, 16'h03e8);
    wr(A_PR + 8'h02, 16'hf000);
    rd(A_PR + 8'h02, 16'hfc18);
    wr(A_TM + 8'h01, 16'hffff);
    rd(A_TM + 8'h01, 16'hfde8);
    for (int k = 0; k < 4; k++) begin
      wr(A_AC + 8'h04, 16'(k));
      rd(A_AC + 8'h04, 16'(k));
    end
    sel(4'h5, 16'h01f4, 17'h009c4, 17'h000be);
    sel(4'h3, 16'hff06, 17'h1fb1e, 17'h1ffa1);
    sel(4'hf, 16'h03e8, 17'h01388, 17'h0017c);
    sel(4'h8, 16'hfc18, 17'h1ec78, 17'h1fe84);
    wr(A_PR, 16'h0064);
    @(posedge core_clk) preset_sel_pins <= 4'h0;
    for (int c = 0; c < 8; c++) begin
      wr(A_CT, 16'(c) << 5);
      cyc(8);
      check(17'(pid_setpoint), 17'(src_exp[c]));
    end
    prog();
    wr(A_CT, 16'h0000);
    run(1'b1);
    check(17'(seq_running), 17'h00001);
    check(17'(accel_sel), 17'h00001);
    wait_stage(4'h2);
    cyc(1);
    check(17'(accel_sel), 17'h00002);
    wait_run(1'b0);
    cyc(20);
    check(17'(seq_running), 17'h00000);
    run(1'b0);
    wr(A_CT, 16'h0001);
    run(1'b1);
    wait_stage(4'h2);
    cyc(60);
    check(17'(seq_running), 17'h00001);
    check(17'(seq_stage), 17'h00002);
    rd(psq_pkg::ADDR_STATUS, 16'h030f);
    run(1'b0);
    wait_run(1'b0);
    wr(A_CT, 16'h0002);
    run(1'b1);
    wait_stage(4'h2);
    run(1'b0);
    wait_run(1'b0);
    run(1'b1);
    check(17'(seq_stage), 17'h00000);
    wait_stage(4'h2);
    wait_stage(4'h0);
    run(1'b0);
    wait_run(1'b0);
    wr(A_CT, 16'h000a);
    run(1'b1);
    wait_stage(4'h2);
    cyc(4);
    run(1'b0);
    wait_run(1'b0);
    check(resume_freq, 17'h1ec78);
    run(1'b1);
    check(17'(seq_stage), 17'h00002);
    run(1'b0);
    wait_run(1'b0);
    wr(A_CT, 16'h0010);
    run(1'b1);
    cyc(60);
    check(17'(seq_stage), 17'h00000);
    run(1'b0);
    wait_run(1'b0);
    wr(A_CT, 16'h0006);
    run(1'b1);
    wait_stage(4'h2);
    @(posedge core_clk) power_fail <= 1'b1;
    cyc(8);
    @(posedge core_clk) reset <= 1'b1;
    run_cmd    <= 1'b0;
    power_fail <= 1'b0;
    cyc(3);
    @(posedge core_clk) reset <= 1'b0;
    cyc(2);
    check(resume_freq, 17'h1ec78);
    prog();
    wr(A_CT, 16'h0006);
    run(1'b1);
    check(17'(seq_stage), 17'h00002);
    give_verdict();
  end
endmodule // test_psq_top
`default_nettype wire
